/* src/conv_sync_ctrl.sv */
// Conversion control for a free-running sigma-delta converter: modulator
// tick, filter notch update, output coding, sync and calibration restart.
// Assumes modulator samples arrive on sample_i, one per modulator tick.
//
// Functional notes
// - One polarity bit sets unipolar or bipolar for both channels.
// - Polarity only changes coding: binary unipolar, offset binary bipolar.
// - Reference sampled every 256 master clocks regardless of gain.
// - Conversion runs continuously with no start request.
// - Result register refreshed once per notch period except during calibration passes; readable anytime.
// - All rates and calibration time count master clock cycles.
// - Falling edge on active-low sync resets filter to known state.
// - Common sync and clock make several converters update together.
// - Any calibration command also resets the digital filter.
// - Result ready goes low when calibration and resettling complete.
`timescale 1ns/1ns
`default_nettype none
module conv_sync_ctrl
    import conv_sync_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire conv_cfg_t         cfg_i,
    input  wire logic              sync_n_i,
    input  wire logic [DATA_W-1:0] sample_i,
    output logic                   mod_tick_o,
    output logic                   ref_sample_o,
    output logic                   cal_busy_o,
    output logic [DATA_W-1:0]      result_o,
    output logic                   result_ready_n
);
    // =========================================================
    // Reset
    // =========================================================
    logic rst_n;

    rst_sync u_rst_sync
    (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .rstn_o (rst_n)
    );

    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic is_cal(input operating_mode_field_t m);
        is_cal = (m == MODE_SELF_CAL) || (m == MODE_SYS_ZERO) ||
                 (m == MODE_SYS_FULL) || (m == MODE_SYS_OFFS) ||
                 (m == MODE_BKG_CAL);
    endfunction

    // Bipolar flips the MSB, turning two's-complement into offset binary
    function automatic logic [DATA_W-1:0] code(input logic [DATA_W-1:0] v,
                                               input logic bip);
        code = bip ? (v ^ BIPOLAR_FLIP) : v;
    endfunction

    // =========================================================
    // Sync edge and filter restart
    // =========================================================
    logic sync_prev_q;
    logic sync_fall;
    logic cal_cmd;
    logic filt_rst;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            sync_prev_q <= 1'b1;
        else
            sync_prev_q <= sync_n_i;
    end

    assign sync_fall = sync_prev_q && !sync_n_i;
    assign cal_cmd   = cfg_i.mode_wr && is_cal(cfg_i.mode);
    assign filt_rst  = sync_fall || cal_cmd;

    // =========================================================
    // Modulator tick and notch counters
    // =========================================================
    logic [7:0]         mod_cnt_q, mod_cnt_d;
    logic [NOTCH_W-1:0] notch_q,   notch_d;
    logic               tick;
    logic               notch_hit;

    // Counting only clk_i edges ties every rate to the master clock
    assign tick      = (mod_cnt_q == MOD_CNT_MAX);
    assign notch_hit = tick && (notch_q >= cfg_i.notch_div);

    always_comb
    begin
        mod_cnt_d = mod_cnt_q + 8'h01;
        notch_d   = notch_q;
        if (tick)
            notch_d = notch_hit ? NOTCH_RST : notch_q + 12'h001;
        if (filt_rst)
        begin
            mod_cnt_d = MOD_CNT_RST;
            notch_d   = NOTCH_RST;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mod_cnt_q <= MOD_CNT_RST;
            notch_q   <= NOTCH_RST;
        end
        else
        begin
            mod_cnt_q <= mod_cnt_d;
            notch_q   <= notch_d;
        end
    end

    assign mod_tick_o   = tick;
    assign ref_sample_o = tick;

    // =========================================================
    // Calibration sequencing
    // =========================================================
    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_CAL    = 3'b010,
        ST_SETTLE = 3'b100
    } cal_state_t;

    cal_state_t       st_q, st_d;
    logic [CAL_W-1:0] cal_cnt_q, cal_cnt_d;

    // Calibration time is a fixed count of notch periods, so it scales
    // inversely with the master clock
    always_comb
    begin
        st_d      = st_q;
        cal_cnt_d = cal_cnt_q;
        case (st_q)
            ST_RUN:
            begin
                cal_cnt_d = CAL_RST;
            end
            ST_CAL:
            begin
                if (notch_hit)
                begin
                    cal_cnt_d = cal_cnt_q + 4'h1;
                    if (cal_cnt_q + 4'h1 >= CAL_PASSES)
                        st_d = ST_SETTLE;
                end
            end
            ST_SETTLE:
            begin
                if (notch_hit)
                    st_d = ST_RUN;
            end
            default:
            begin
                st_d = ST_RUN;
            end
        endcase
        if (cal_cmd)
        begin
            st_d      = ST_CAL;
            cal_cnt_d = CAL_RST;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q      <= ST_RUN;
            cal_cnt_q <= CAL_RST;
        end
        else
        begin
            st_q      <= st_d;
            cal_cnt_q <= cal_cnt_d;
        end
    end

    assign cal_busy_o = (st_q != ST_RUN);

    // =========================================================
    // Result register and ready flag
    // =========================================================
    logic [DATA_W-1:0] res_q, res_d;
    logic              rdy_n_q, rdy_n_d;
    logic              publish;

    assign publish = notch_hit && (st_q != ST_CAL);

    always_comb
    begin
        res_d   = res_q;
        rdy_n_d = rdy_n_q;
        if (publish)
        begin
            res_d   = code(sample_i, cfg_i.bipolar);
            rdy_n_d = 1'b0;
        end
        // Ready rises at once on a calibration command, inside the
        // window the host is told to ignore
        if (cal_cmd)
            rdy_n_d = 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            res_q   <= DATA_RST;
            rdy_n_q <= 1'b1;
        end
        else
        begin
            res_q   <= res_d;
            rdy_n_q <= rdy_n_d;
        end
    end

    assign result_o       = res_q;
    assign result_ready_n = rdy_n_q;

    // =========================================================
    // Checks
    // =========================================================
    sequence s_cal_issue;
        cfg_i.mode_wr && is_cal(cfg_i.mode);
    endsequence

    AST_TICK_PERIOD: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        tick && !filt_rst |=> !tick [*8])
        else $error("modulator tick repeated too soon");

    AST_SYNC_RESET: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        $fell(sync_n_i) |=> mod_cnt_q == MOD_CNT_RST && notch_q == NOTCH_RST)
        else $error("sync fall did not reset filter");

    AST_CAL_RESET: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        s_cal_issue |=> mod_cnt_q == MOD_CNT_RST && st_q == ST_CAL)
        else $error("calibration did not reset filter");

    AST_CAL_READY_HIGH: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        s_cal_issue |=> result_ready_n)
        else $error("ready not high during calibration");

    AST_HOLD: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !$past(publish) |-> $stable(result_o))
        else $error("result changed between updates");

    // Checked bit by bit so the expectation does not reuse the coder
    AST_CODING: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        publish |=>
            result_o[DATA_W-2:0] == $past(sample_i[DATA_W-2:0]) &&
            result_o[DATA_W-1] ==
                ($past(sample_i[DATA_W-1]) ^ $past(cfg_i.bipolar)))
        else $error("wrong output coding");

    AST_UPDATE_READY: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        publish && !cal_cmd |=> !result_ready_n)
        else $error("ready not low after update");

    // The edge that ends reset still holds the counter, so it is skipped
    AST_FREE_RUN: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        rst_n && !filt_rst |=> mod_cnt_q == $past(mod_cnt_q) + 8'h01)
        else $error("modulator counter stalled");
endmodule
`default_nettype wire

/* common/conv_sync_pkg.sv */
// Package: constants and carriers for the conversion sync controller.
// Assumes a single master clock; all rates derive from it.
package conv_sync_pkg;

    // =========================================================
    // Timing
    // =========================================================
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned REF_SAMPLE_DIV = 256;
    localparam logic [7:0]  MOD_CNT_MAX    = 8'hff;
    localparam logic [7:0]  MOD_CNT_RST    = 8'h00;
    localparam int unsigned NOTCH_W        = 12;
    localparam logic [11:0] NOTCH_RST      = 12'h000;
    localparam int unsigned CAL_W          = 4;
    localparam logic [3:0]  CAL_PASSES     = 4'h4;
    localparam logic [3:0]  CAL_RST        = 4'h0;
    localparam int unsigned DATA_W         = 24;
    localparam logic [23:0] DATA_RST       = 24'h000000;
    localparam logic [23:0] BIPOLAR_FLIP   = 24'h800000;

    // =========================================================
    // Operating mode field codes
    // =========================================================
    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'h0,
        MODE_SELF_CAL = 3'h1,
        MODE_SYS_ZERO = 3'h2,
        MODE_SYS_FULL = 3'h3,
        MODE_SYS_OFFS = 3'h4,
        MODE_BKG_CAL  = 3'h5
    } operating_mode_field_t;

    typedef struct packed {
        logic                  bipolar;
        logic [NOTCH_W-1:0]    notch_div;
        operating_mode_field_t mode;
        logic                  mode_wr;
    } conv_cfg_t;

endpackage

/* src/rst_sync.sv */
// Reset release synchroniser.
// Assumes rstn_i may deassert at any time relative to clk_i.
`timescale 1ns/1ns
`default_nettype none
module rst_sync
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    output logic      rstn_o
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= 1'b1;
            sync_q <= meta_q;
        end
    end

    assign rstn_o = sync_q;
endmodule
`default_nettype wire

/* verif/host_model.sv */
// Host model: drives config, sync and the filtered words.
// Assumes the bench calls its tasks at falling edges.
`timescale 1ns/1ns
`default_nettype none
module host_model
    import conv_sync_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         tick_i,
    input  wire logic         ready_n_i,
    output conv_cfg_t         cfg_o,
    output logic              sync_n_o,
    output logic [DATA_W-1:0] sample_o
);
    int age  = 0;
    int seed = 15;
    // ==========
    // Stimulus
    initial
    begin
        cfg_o    = '0;
        sync_n_o = 1'b1;
        sample_o = DATA_RST;
    end
    // New word far from any notch edge, so publish timing is moot
    always @(negedge clk_i)
    begin
        age <= tick_i ? 0 : age + 1;
        if (age == 8)
            sample_o <= DATA_W'($random(seed));
    end
    task automatic set_cfg(input logic b, input logic [NOTCH_W-1:0] d);
        cfg_o.bipolar   = b;
        cfg_o.notch_div = d;
    endtask
    task automatic pulse_sync();
        @(negedge clk_i);
        sync_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        sync_n_o = 1'b1;
    endtask
    task automatic send_mode(input operating_mode_field_t m);
        @(negedge clk_i);
        cfg_o.mode    = m;
        cfg_o.mode_wr = 1'b1;
        @(negedge clk_i);
        cfg_o.mode_wr = 1'b0;
    endtask
    // Ready is not trusted during the first modulator cycle
    task automatic await_done(input int lim, output int n, output int fst);
        n   = 1;
        fst = 0;
        while ((n <= REF_SAMPLE_DIV || ready_n_i !== 1'b0) && n < lim)
        begin
            @(negedge clk_i);
            n++;
            if (fst == 0 && tick_i === 1'b1)
                fst = n;
        end
    endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Bench: two converters on one clock, one host model.
// Assumes the reset synchroniser sits inside the design top.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import conv_sync_pkg::*;
;
    logic              clk_i  = 1'b0;
    logic              rstn_i = 1'b0;
    logic              rstn_b = 1'b0;
    logic              bip    = 1'b0;
    logic              mon_on = 1'b0;
    conv_cfg_t         cfg;
    logic              sync_n;
    logic [DATA_W-1:0] sample, res, res_b, last_res;
    logic              tick, ref_s, busy, rdy_n, tick_b;
    int                n_fail = 0, n_tests = 0, cyc = 0, last_at = 0;
    int                per, n, fst, seed = 15, last_ref = 0;
    // ==========
    // Structure
    always #50 clk_i = ~clk_i;
    conv_sync_ctrl u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg),
        .sync_n_i(sync_n), .sample_i(sample), .mod_tick_o(tick),
        .ref_sample_o(ref_s), .cal_busy_o(busy), .result_o(res),
        .result_ready_n(rdy_n));
    conv_sync_ctrl u_dut_b (.clk_i(clk_i), .rstn_i(rstn_b), .cfg_i(cfg),
        .sync_n_i(sync_n), .sample_i(sample), .mod_tick_o(tick_b),
        .ref_sample_o(), .cal_busy_o(), .result_o(res_b),
        .result_ready_n());
    host_model u_host (.clk_i(clk_i), .tick_i(tick), .ready_n_i(rdy_n),
        .cfg_o(cfg), .sync_n_o(sync_n), .sample_o(sample));
    // ==========
    // Checking
    function automatic logic [DATA_W-1:0] code(input logic [DATA_W-1:0] s);
        return bip ? (s ^ BIPOLAR_FLIP) : s;
    endfunction
    task automatic check(input string what,
                         input logic [DATA_W-1:0] exp, got);
        n_tests++;
        if (exp !== got)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Keeps changes clear of any notch edge
    task automatic off_tick();
        @(negedge clk_i iff tick === 1'b1);
        repeat (2 + {$random(seed)} % 200) @(negedge clk_i);
    endtask
    always @(negedge clk_i)
    begin
        cyc++;
        check("ref tick", 24'(tick), 24'(ref_s));
        if (mon_on)
        begin
            check("peer tick", 24'(tick), 24'(tick_b));
            if (ref_s === 1'b1)
            begin
                if (last_ref != 0)
                    check("ref period", 24'(REF_SAMPLE_DIV),
                          24'(cyc - last_ref));
                last_ref = cyc;
            end
            if (res !== last_res)
            begin
                check("result", code(sample), res);
                check("peer result", res, res_b);
                check("ready", 24'h0, 24'(rdy_n));
                if (last_at != 0)
                    check("interval", 24'(per), 24'(cyc - last_at));
                last_at  = cyc;
                last_res = res;
            end
        end
        if (cyc == 60000)
        begin
            n_fail++;
            complete_run();
        end
    end
    // ==========
    // Sequence
    initial
    begin
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (37) @(negedge clk_i);
        rstn_b = 1'b1;
        per = 256 * (2 + {$random(seed)} % 2);
        u_host.set_cfg(1'b0, 12'(per / 256 - 1));
        repeat (600) @(negedge clk_i);
        u_host.pulse_sync();
        last_res = res;
        mon_on   = 1'b1;
        repeat (4 * per) @(negedge clk_i);
        check("updates", 24'h1, 24'(last_at != 0));
        off_tick();
        bip = 1'b1;
        u_host.set_cfg(1'b1, cfg.notch_div);
        repeat (3 * per) @(negedge clk_i);
        for (int m = 0; m < 6; m++)
        begin
            off_tick();
            u_host.send_mode(operating_mode_field_t'(m));
            last_at  = 0;
            last_ref = 0;
            check("busy", 24'(m != 0), 24'(busy));
            check("ready high", 24'(m != 0), 24'(rdy_n));
            if (m != 0)
            begin
                u_host.await_done(6 * per, n, fst);
                check("first tick", 24'h1,
                      24'(fst >= 255 && fst <= 258));
                check("cal len", 24'h1,
                      24'(n >= 5 * per - 2 && n <= 5 * per + 3));
                check("busy end", 24'h0, 24'(busy));
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
